// ===== verilog/prsc_pkg.sv
// Package: register map, field layout and decode helpers for the clock control block
`default_nettype none
package prsc_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam int unsigned   IDX_W                = 15;
  localparam logic [14:0]   IDX_FAST_PRESCALER   = 15'h701a;
  localparam logic [14:0]   IDX_SLOW_PRESCALER   = 15'h701b;
  localparam logic [14:0]   IDX_PERIPH_CLK_EN    = 15'h701c;
  localparam logic [14:0]   IDX_LOW_POWER_0      = 15'h701e;
  localparam logic [14:0]   IDX_LOW_POWER_1      = 15'h701f;
  localparam logic [14:0]   IDX_PLL_RATIO        = 15'h7021;
  localparam logic [14:0]   IDX_SYS_CTRL_STATUS  = 15'h7022;
  localparam logic [14:0]   IDX_WD_COUNT         = 15'h7023;
  localparam logic [14:0]   IDX_WD_KEY           = 15'h7025;
  localparam logic [14:0]   IDX_WD_CONTROL       = 15'h7029;
  localparam logic [14:0]   IDX_PROTECT_CONTROL  = 15'h7030;
  localparam logic [14:0]   IDX_CLOCK_STATUS     = 15'h7031;

  // ==========================================================================
  // Field layout and reset values
  localparam int unsigned   REG_W                = 16;
  localparam int unsigned   RATIO_W              = 4;
  localparam logic [3:0]    RATIO_RESET          = 4'h0;
  localparam logic [3:0]    RATIO_BYPASS         = 4'h0;
  localparam logic [3:0]    RATIO_CODE_MAX       = 4'ha;
  localparam logic [15:0]   CFG_RESET            = 16'h0000;
  localparam int unsigned   PROT_OPEN_BIT        = 0;
  localparam int unsigned   STAT_LOCKED_BIT      = 0;
  localparam int unsigned   STAT_DISABLED_BIT    = 1;
  localparam int unsigned   STAT_PLL_ON_BIT      = 2;
  localparam logic [3:0]    NUM_ONE              = 4'h1;
  localparam logic [1:0]    DEN_ONE              = 2'h1;
  localparam logic [1:0]    DEN_TWO              = 2'h2;
  localparam int unsigned   LOCK_CYCLES_DEFAULT  = 131072;

  // ==========================================================================
  // AXI responses
  localparam logic [1:0]    RESP_OKAY            = 2'h0;
  localparam logic [1:0]    RESP_SLVERR          = 2'h2;
  localparam logic [1:0]    RESP_DECERR          = 2'h3;

  // Storage slots first, so a slot doubles as the storage index
  typedef enum {
    SL_FAST, SL_SLOW, SL_PCLK, SL_LPM0, SL_LPM1, SL_SYSTEM_CONTROL_STATUS, SL_WATCHDOG_SERVICE_KEY, SL_WATCHDOG_CONTROL,
    SL_PLL, SL_WDCNT, SL_PROT, SL_CSTAT, SL_NONE
  } prsc_slot_e;

  localparam int unsigned   CFG_N                = 8;

  function automatic prsc_slot_e prsc_slot_of(input logic [14:0] idx);
    case (idx)
      IDX_FAST_PRESCALER:  prsc_slot_of = SL_FAST;
      IDX_SLOW_PRESCALER:  prsc_slot_of = SL_SLOW;
      IDX_PERIPH_CLK_EN:   prsc_slot_of = SL_PCLK;
      IDX_LOW_POWER_0:     prsc_slot_of = SL_LPM0;
      IDX_LOW_POWER_1:     prsc_slot_of = SL_LPM1;
      IDX_PLL_RATIO:       prsc_slot_of = SL_PLL;
      IDX_SYS_CTRL_STATUS: prsc_slot_of = SL_SYSTEM_CONTROL_STATUS;
      IDX_WD_COUNT:        prsc_slot_of = SL_WDCNT;
      IDX_WD_KEY:          prsc_slot_of = SL_WATCHDOG_SERVICE_KEY;
      IDX_WD_CONTROL:      prsc_slot_of = SL_WATCHDOG_CONTROL;
      IDX_PROTECT_CONTROL: prsc_slot_of = SL_PROT;
      IDX_CLOCK_STATUS:    prsc_slot_of = SL_CSTAT;
      default:             prsc_slot_of = SL_NONE;
    endcase
  endfunction : prsc_slot_of

  // Every documented register except the protection control and clock status sits behind the protection gate
  function automatic logic prsc_guarded(input prsc_slot_e s);
    prsc_guarded = (s != SL_PROT) && (s != SL_CSTAT) && (s != SL_NONE);
  endfunction : prsc_guarded

  function automatic logic [15:0] prsc_merge(input logic [15:0] old,
                                             input logic [15:0] wd,
                                             input logic [1:0]  ws);
    prsc_merge = {ws[1] ? wd[15:8] : old[15:8], ws[0] ? wd[7:0] : old[7:0]};
  endfunction : prsc_merge

endpackage : prsc_pkg

`default_nettype wire

// ===== verilog/prsc_pll_ctrl.sv
// PLL ratio decode and lock wait counter
`timescale 1ns/100ps
`default_nettype none

module prsc_pll_ctrl
  import prsc_pkg::*;
#(
  parameter int unsigned LOCK_CYCLES = LOCK_CYCLES_DEFAULT
) (
  input  wire logic               aclk,
  input  wire logic               ext_reset_n,
  input  wire logic [RATIO_W-1:0] ratio,
  input  wire logic               pll_disabled,
  input  wire logic               restart,
  output logic                    pll_on,
  output logic      [RATIO_W-1:0] clk_num,
  output logic      [1:0]         clk_den,
  output logic                    locked
);

  localparam int unsigned CNT_W = $clog2(LOCK_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(LOCK_CYCLES);

  if (LOCK_CYCLES < 1) begin : g_bad_lock
    $error("LOCK_CYCLES must be at least one");
  end

  logic [CNT_W-1:0] lock_cnt;

  // ==========================================================================
  // Ratio decode: clock = input * num / den
  always_comb begin
    pll_on  = !pll_disabled && (ratio != RATIO_BYPASS);
    clk_num = NUM_ONE;
    clk_den = DEN_TWO;
    if (pll_disabled) begin
      clk_den = DEN_ONE;
    end else if (ratio != RATIO_BYPASS) begin
      clk_num = ratio;
    end
  end

  // ==========================================================================
  // Lock wait, counted in input clock cycles; a bypassed PLL needs none
  always_ff @(posedge aclk) begin
    if (!ext_reset_n) begin
      lock_cnt <= '0;
    end else if (restart) begin
      lock_cnt <= CNT_LOAD;
    end else if (lock_cnt != '0) begin
      lock_cnt <= lock_cnt - CNT_W'(1);
    end
  end

  assign locked = !pll_on || (lock_cnt == '0);

endmodule : prsc_pll_ctrl

`default_nettype wire

// ===== verilog/prsc_top.sv
// Top: AXI4-Lite register slave for the PLL ratio and system clock control group
`timescale 1ns/100ps
`default_nettype none


module prsc_top
  import prsc_pkg::*;
#(
  parameter int unsigned ADDR_W      = 17,
  parameter int unsigned LOCK_CYCLES = LOCK_CYCLES_DEFAULT
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               external_reset_pin_n,
  input  wire logic               pll_disable_pin_n,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]  awaddr,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output logic                    wready,
  output logic      [1:0]         bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  input  wire logic [ADDR_W-1:0]  araddr,
  input  wire logic               arvalid,
  output logic                    arready,
  output logic      [31:0]        rdata,
  output logic      [1:0]         rresp,
  output logic                    rvalid,
  input  wire logic               rready,
  // Clock generation controls
  output logic                    pll_enable,
  output logic      [RATIO_W-1:0] pll_mult,
  output logic      [RATIO_W-1:0] cpu_clock_in_num,
  output logic      [1:0]         cpu_clock_in_den,
  output logic      [RATIO_W-1:0] system_clock_out_num,
  output logic      [1:0]         system_clock_out_den,
  output logic                    pll_locked,
  output logic                    protected_write_enable,
  // Peripheral clocking, low-power and watchdog settings
  output logic      [REG_W-1:0]   fast_prescaler,
  output logic      [REG_W-1:0]   slow_prescaler,
  output logic      [REG_W-1:0]   periph_clk_enables,
  output logic      [REG_W-1:0]   low_power_ctrl0,
  output logic      [REG_W-1:0]   low_power_ctrl1,
  output logic      [REG_W-1:0]   watchdog_ctrl
);

  if (ADDR_W < IDX_W + 2) begin : g_bad_addr
    $error("ADDR_W too narrow for the register map");
  end

  // The lock counter needs a nonzero load
  if (LOCK_CYCLES < 1) begin : g_bad_lock
    $error("LOCK_CYCLES must be at least one");
  end

  // ==========================================================================
  // Declarations
  logic                    sys_reset;
  logic [REG_W-1:0]        cfg [CFG_N];
  logic [RATIO_W-1:0]      pll_ratio_register;
  logic                    pll_disabled;
  logic                    aw_held;
  logic                    w_held;
  logic [IDX_W-1:0]        aw_idx;
  logic [REG_W-1:0]        w_data;
  logic [1:0]              w_strb;
  prsc_slot_e              wr_slot;
  prsc_slot_e              rd_slot;
  logic                    wr_go;
  logic [1:0]              next_bresp;
  logic [REG_W-1:0]        wr_merged;
  logic                    wr_store;
  logic                    ratio_write;
  logic [31:0]             next_rdata;
  logic [1:0]              next_rresp;
  logic                    dec_pll_on;
  logic [RATIO_W-1:0]      dec_num;
  logic [1:0]              dec_den;
  logic                    dec_locked;

  // ==========================================================================
  // Helpers
  function automatic logic [IDX_W-1:0] word_idx(input logic [ADDR_W-1:0] a);
    word_idx = a[IDX_W+1:2];
  endfunction : word_idx

  // Slots past storage fold onto slot 0; their value is never used
  function automatic int cfg_slot(input prsc_slot_e s);
    cfg_slot = (s < SL_PLL) ? int'(s) : 0;
  endfunction : cfg_slot

  // Either reset clears the ordinary state; only the pin clears the ratio
  assign sys_reset = !aresetn || !external_reset_pin_n;

  // ==========================================================================
  // Strap capture
  // The strap is sampled for as long as the pin reset is held, so its level
  // at release is what counts; a debug reset keeps the captured mode.
  always_ff @(posedge aclk) begin
    if (!external_reset_pin_n) begin
      pll_disabled <= !pll_disable_pin_n;
    end
  end

  // ==========================================================================
  // Write channel
  assign wr_slot = prsc_slot_of(aw_idx);
  // One response in flight; the next pair waits for it
  assign wr_go   = aw_held && w_held && !bvalid;
  assign wr_merged = (wr_slot == SL_PLL)
                   ? prsc_merge({{(REG_W-RATIO_W){1'b0}}, pll_ratio_register},
                                w_data, w_strb)
                   : prsc_merge(cfg[cfg_slot(wr_slot)],
                                w_data, w_strb);

  always_comb begin
    next_bresp = RESP_OKAY;
    wr_store   = 1'b0;
    if (wr_slot == SL_NONE) begin
      next_bresp = RESP_DECERR;
    end else if (prsc_guarded(wr_slot) && !protected_write_enable) begin
      next_bresp = RESP_SLVERR;
    end else if (wr_slot == SL_PLL && wr_merged[RATIO_W-1:0] > RATIO_CODE_MAX) begin
      // Reserved codes never reach the PLL; the old ratio stays
      next_bresp = RESP_SLVERR;
    end else begin
      wr_store = 1'b1;
    end
  end

  assign ratio_write = wr_go && wr_store && (wr_slot == SL_PLL);

  // Address and data are taken independently, in either order
  always_ff @(posedge aclk) begin
    if (sys_reset) begin
      aw_held <= 1'b0;
      aw_idx  <= '0;
      awready <= 1'b0;
    end else if (awvalid && awready) begin
      aw_held <= 1'b1;
      aw_idx  <= word_idx(awaddr);
      awready <= 1'b0;
    end else begin
      if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (!aw_held && !bvalid) begin
        awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (sys_reset) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      wready <= 1'b0;
    end else if (wvalid && wready) begin
      w_held <= 1'b1;
      w_data <= wdata[REG_W-1:0];
      w_strb <= wstrb[1:0];
      wready <= 1'b0;
    end else begin
      if (wr_go) begin
        w_held <= 1'b0;
      end
      if (!w_held && !bvalid) begin
        wready <= 1'b1;
      end
    end
  end

  // Response waits for both halves; a lone beat stays parked
  always_ff @(posedge aclk) begin
    if (sys_reset) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp  <= next_bresp;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Register storage
  // Only the storage slots live in cfg; the ratio and the gate have registers of their own
  always_ff @(posedge aclk) begin
    if (sys_reset) begin
      for (int i = 0; i < CFG_N; i++) begin
        cfg[i] <= CFG_RESET;
      end
    end else if (wr_go && wr_store && wr_slot < SL_PLL) begin
      cfg[int'(wr_slot)] <= wr_merged;
    end
  end

  // A debug reset must not disturb a running clock ratio
  always_ff @(posedge aclk) begin
    if (!external_reset_pin_n) begin
      pll_ratio_register <= RATIO_RESET;
    end else if (ratio_write) begin
      pll_ratio_register <= wr_merged[RATIO_W-1:0];
    end
  end

  // The gate itself stays reachable, otherwise it could never be opened
  always_ff @(posedge aclk) begin
    if (sys_reset) begin
      protected_write_enable <= 1'b0;
    end else if (wr_go && wr_slot == SL_PROT) begin
      if (w_strb[0]) begin
        protected_write_enable <= w_data[PROT_OPEN_BIT];
      end
    end
  end

  // ==========================================================================
  // Read channel: answer one cycle after the address is taken
  assign rd_slot = prsc_slot_of(word_idx(araddr));

  // A closed gate blanks read data too, so nothing leaks
  always_comb begin
    next_rdata = '0;
    next_rresp = RESP_OKAY;
    if (rd_slot == SL_NONE) begin
      next_rresp = RESP_DECERR;
    end else if (prsc_guarded(rd_slot) && !protected_write_enable) begin
      next_rresp = RESP_SLVERR;
    end else begin
      case (rd_slot)
        SL_PLL: begin
          next_rdata[RATIO_W-1:0] = pll_ratio_register;
        end
        SL_WDCNT: begin
          next_rdata = '0;
        end
        SL_PROT: begin
          next_rdata[PROT_OPEN_BIT] = protected_write_enable;
        end
        SL_CSTAT: begin
          next_rdata[STAT_LOCKED_BIT]   = pll_locked;
          next_rdata[STAT_DISABLED_BIT] = pll_disabled;
          next_rdata[STAT_PLL_ON_BIT]   = pll_enable;
        end
        default: begin
          next_rdata[REG_W-1:0] = cfg[cfg_slot(rd_slot)];
        end
      endcase
    end
  end

  // Data latched at the address handshake, held until taken
  always_ff @(posedge aclk) begin
    if (sys_reset) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  // ==========================================================================
  // Clock ratio decode and lock wait
  prsc_pll_ctrl #(
    .LOCK_CYCLES (LOCK_CYCLES)
  ) u_pll_ctrl (
    .aclk         (aclk),
    .ext_reset_n  (external_reset_pin_n),
    .ratio        (pll_ratio_register),
    .pll_disabled (pll_disabled),
    .restart      (ratio_write),
    .pll_on       (dec_pll_on),
    .clk_num      (dec_num),
    .clk_den      (dec_den),
    .locked       (dec_locked)
  );

  // Both clock ratio outputs load from one decode on the same edge,
  // so the two can never disagree, not even for a cycle.
  always_ff @(posedge aclk) begin
    if (!external_reset_pin_n) begin
      cpu_clock_in_num     <= NUM_ONE;
      cpu_clock_in_den     <= DEN_TWO;
      system_clock_out_num <= NUM_ONE;
      system_clock_out_den <= DEN_TWO;
    end else begin
      cpu_clock_in_num     <= dec_num;
      cpu_clock_in_den     <= dec_den;
      system_clock_out_num <= dec_num;
      system_clock_out_den <= dec_den;
    end
  end

  // PLL controls follow the pin reset only, like the ratio
  always_ff @(posedge aclk) begin
    if (!external_reset_pin_n) begin
      pll_enable <= 1'b0;
      pll_mult   <= RATIO_RESET;
      pll_locked <= 1'b1;
    end else begin
      pll_enable <= dec_pll_on;
      pll_mult   <= dec_pll_on ? pll_ratio_register : RATIO_BYPASS;
      pll_locked <= dec_locked;
    end
  end

  // ==========================================================================
  // Settings handed to the prescalers, clock gates, low-power and watchdog
  assign fast_prescaler     = cfg[int'(SL_FAST)];
  assign slow_prescaler     = cfg[int'(SL_SLOW)];
  assign periph_clk_enables = cfg[int'(SL_PCLK)];
  assign low_power_ctrl0    = cfg[int'(SL_LPM0)];
  assign low_power_ctrl1    = cfg[int'(SL_LPM1)];
  assign watchdog_ctrl      = cfg[int'(SL_WATCHDOG_CONTROL)];

endmodule : prsc_top

`default_nettype wire

// ===== sim/prsc_chk.sv
// Checker: concurrent properties on the clock control block ports
`timescale 1ns/100ps
`default_nettype none

module prsc_chk
  import prsc_pkg::*;
#(
  parameter int unsigned LOCK_CYCLES = LOCK_CYCLES_DEFAULT
) (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               external_reset_pin_n,
  input wire logic               pll_disable_pin_n,
  input wire logic [1:0]         bresp,
  input wire logic               bvalid,
  input wire logic               bready,
  input wire logic [31:0]        rdata,
  input wire logic               rvalid,
  input wire logic               rready,
  input wire logic               pll_enable,
  input wire logic [RATIO_W-1:0] pll_mult,
  input wire logic [RATIO_W-1:0] cpu_clock_in_num,
  input wire logic [1:0]         cpu_clock_in_den,
  input wire logic [RATIO_W-1:0] system_clock_out_num,
  input wire logic [1:0]         system_clock_out_den,
  input wire logic               pll_locked,
  input wire logic               protected_write_enable,
  input wire logic [REG_W-1:0]   fast_prescaler,
  input wire logic [REG_W-1:0]   watchdog_ctrl
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !external_reset_pin_n);

  // ==========================================================================
  // Lock wait length, counted only by the pin reset domain
  logic [17:0] lo_cnt;
  always_ff @(posedge aclk) begin
    if (!external_reset_pin_n || pll_locked) lo_cnt <= '0;
    else lo_cnt <= lo_cnt + 18'h1;
  end

  // ==========================================================================
  // Properties
  a_clk_match: assert property ({cpu_clock_in_num, cpu_clock_in_den} ==
    {system_clock_out_num, system_clock_out_den}) else $error("cpu and system clocks differ");
  a_code_range: assert property (pll_mult <= RATIO_CODE_MAX)
    else $error("reserved ratio code reached the pll");
  a_ratio_scale: assert property (pll_enable |-> cpu_clock_in_num == pll_mult
    && cpu_clock_in_den == DEN_TWO) else $error("ratio scaling wrong");
  a_strap_direct: assert property ($rose(external_reset_pin_n) && !pll_disable_pin_n
    |-> ##[0:2] (cpu_clock_in_num == NUM_ONE && cpu_clock_in_den == DEN_ONE && !pll_enable))
    else $error("disable strap did not give the input clock");
  a_lock_restart: assert property ($changed(pll_mult) && pll_mult != RATIO_BYPASS
    |=> !pll_locked) else $error("ratio change did not restart lock wait");
  a_lock_length: assert property ($rose(pll_locked) |-> lo_cnt >= 18'(LOCK_CYCLES - 2)
    && lo_cnt <= 18'(LOCK_CYCLES + 2)) else $error("lock wait length wrong");
  a_gate_write: assert property ($changed(fast_prescaler) || $changed(watchdog_ctrl)
    |-> $past(protected_write_enable)) else $error("guarded register changed while closed");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped before taken");

  c_write: cover property (bvalid && bready);
  c_read: cover property (rvalid && rready);
  c_lock: cover property ($rose(pll_locked));
endmodule : prsc_chk

bind prsc_top prsc_chk #(.LOCK_CYCLES(LOCK_CYCLES)) prsc_chk_i (
  .aclk(aclk), .aresetn(aresetn), .external_reset_pin_n(external_reset_pin_n),
  .pll_disable_pin_n(pll_disable_pin_n), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .rdata(rdata), .rvalid(rvalid), .rready(rready), .pll_enable(pll_enable),
  .pll_mult(pll_mult), .cpu_clock_in_num(cpu_clock_in_num),
  .cpu_clock_in_den(cpu_clock_in_den), .system_clock_out_num(system_clock_out_num),
  .system_clock_out_den(system_clock_out_den), .pll_locked(pll_locked),
  .protected_write_enable(protected_write_enable), .fast_prescaler(fast_prescaler),
  .watchdog_ctrl(watchdog_ctrl));

`default_nettype wire

// ===== sim/prsc_osc_model.sv
// Board side model: reset pin and pll disable strap
`timescale 1ns/100ps
`default_nettype none

module prsc_osc_model (
  input  wire logic aclk,
  output logic      external_reset_pin_n,
  output logic      pll_disable_pin_n
);
  // Power-on pin reset, released with the bench reset
  initial begin
    external_reset_pin_n = 1'b0;
    pll_disable_pin_n = 1'b1;
    repeat (3) @(posedge aclk);
    external_reset_pin_n <= 1'b1;
  end

  task automatic pin_reset(input logic strap_n);
    pll_disable_pin_n <= strap_n;
    external_reset_pin_n <= 1'b0;
    repeat (3) @(posedge aclk);
    external_reset_pin_n <= 1'b1;
    @(posedge aclk);
    // Strap has a pull-up, so the design must hold what it captured
    pll_disable_pin_n <= 1'b1;
  endtask : pin_reset
endmodule : prsc_osc_model

`default_nettype wire

// ===== sim/prsc_top_test.sv
// Self-checking bench for the clock control register block
`timescale 1ns/100ps
`default_nettype none

module prsc_top_test;
  import prsc_pkg::*;
  localparam int unsigned LOCK = 16;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [16:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  wire logic   ext_n, strap_n, awready, wready, bvalid, arready, rvalid;
  wire logic   pll_enable, pll_locked, gate;
  wire logic [1:0]  bresp, rresp, cden, sden;
  wire logic [31:0] rdata;
  wire logic [3:0]  pll_mult, cnum, snum;
  wire logic [15:0] fast, slow, pclk, lp0, lp1, wdc;
  logic [1:0]  bq[$];
  logic [33:0] rq[$];
  logic [33:0] re;
  logic [15:0] vs[6];
  logic [14:0] gi[6];
  logic [3:0]  cur;
  int          bad_count, n_compared;

  prsc_osc_model prsc_osc_model_i (.aclk(aclk), .external_reset_pin_n(ext_n),
    .pll_disable_pin_n(strap_n));
  prsc_top #(.LOCK_CYCLES(LOCK)) prsc_top_i (.aclk(aclk), .aresetn(aresetn),
    .external_reset_pin_n(ext_n), .pll_disable_pin_n(strap_n), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .pll_enable(pll_enable), .pll_mult(pll_mult), .cpu_clock_in_num(cnum),
    .cpu_clock_in_den(cden), .system_clock_out_num(snum), .system_clock_out_den(sden),
    .pll_locked(pll_locked), .protected_write_enable(gate), .fast_prescaler(fast),
    .slow_prescaler(slow), .periph_clk_enables(pclk), .low_power_ctrl0(lp0),
    .low_power_ctrl1(lp1), .watchdog_ctrl(wdc));

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp

  // ==========================================================================
  // Response monitor: oldest expectation against each answer
  always @(posedge aclk) begin
    if (bvalid && bready) cmp("bresp", bq.pop_front(), bresp);
    if (rvalid && rready) begin
      re = rq.pop_front();
      cmp("rresp", re[33:32], rresp);
      cmp("rdata", re[31:0], rdata);
    end
  end

  // Response ready is raised at random to stall the slave
  task automatic wr(input logic [14:0] ix, input logic [15:0] d, input logic [1:0] s,
                    input logic [1:0] r);
    bq.push_back(r);
    awaddr <= {ix, 2'h0};
    wdata <= {16'($urandom), d};
    wstrb <= {2'($urandom), s};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (!bready) bready <= 1'($urandom);
    end while (!(bvalid && bready));
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [14:0] ix, input logic [15:0] d, input logic [1:0] r);
    rq.push_back({r, 16'h0000, d});
    araddr <= {ix, 2'h0};
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (!rready) rready <= 1'($urandom);
    end while (!(rvalid && rready));
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  task automatic open_gate();
    wr(IDX_PROTECT_CONTROL, 16'h0001, 2'h3, RESP_OKAY);
  endtask : open_gate

  task automatic chk_clk(input logic [3:0] c);
    cmp("cpu_num", (c == RATIO_BYPASS) ? NUM_ONE : c, cnum);
    cmp("cpu_den", DEN_TWO, cden);
    cmp("sys_num", (c == RATIO_BYPASS) ? NUM_ONE : c, snum);
    cmp("sys_den", DEN_TWO, sden);
    cmp("pll_mult", c, pll_mult);
    cmp("pll_on", c != RATIO_BYPASS, pll_enable);
    cmp("locked", 1'b1, pll_locked);
  endtask : chk_clk

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  // Whole run is several hundred cycles; this cuts a hang short
  initial begin
    #200000;
    bad_count++;
    report_and_stop();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    gi = '{IDX_FAST_PRESCALER, IDX_SLOW_PRESCALER, IDX_PERIPH_CLK_EN, IDX_LOW_POWER_0,
           IDX_LOW_POWER_1, IDX_WD_CONTROL};
    void'($urandom(48));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(IDX_PLL_RATIO, 16'h0000, RESP_SLVERR);
    wr(IDX_FAST_PRESCALER, 16'h1234, 2'h3, RESP_SLVERR);
    open_gate();
    cmp("gate", 1'b1, gate);
    rd(IDX_FAST_PRESCALER, 16'h0000, RESP_OKAY);
    rd(IDX_PLL_RATIO, 16'(RATIO_RESET), RESP_OKAY);
    rd(15'h7024, 16'h0000, RESP_DECERR);
    wr(15'h7024, 16'h5555, 2'h3, RESP_DECERR);
    $display("test protection done");
    foreach (gi[k]) begin
      vs[k] = 16'($urandom);
      wr(gi[k], vs[k], 2'h3, RESP_OKAY);
      rd(gi[k], vs[k], RESP_OKAY);
    end
    cmp("fast", vs[0], fast);
    cmp("wdctrl", vs[5], wdc);
    cmp("slow", vs[1], slow);
    cmp("pclk", vs[2], pclk);
    cmp("lp0", vs[3], lp0);
    cmp("lp1", vs[4], lp1);
    wr(IDX_SLOW_PRESCALER, 16'habcd, 2'h1, RESP_OKAY);
    rd(IDX_SLOW_PRESCALER, {vs[1][15:8], 8'hcd}, RESP_OKAY);
    wr(IDX_WD_COUNT, 16'h5a5a, 2'h3, RESP_OKAY);
    rd(IDX_WD_COUNT, 16'h0000, RESP_OKAY);
    $display("test registers done");
    cur = RATIO_RESET;
    for (int c = 0; c < 16; c++) begin
      if (c <= 10) cur = c[3:0];
      wr(IDX_PLL_RATIO, {12'($urandom), c[3:0]}, 2'h3,
         (c <= 10) ? RESP_OKAY : RESP_SLVERR);
      rd(IDX_PLL_RATIO, {12'h000, cur}, RESP_OKAY);
      for (int i = 0; i < LOCK * 4 && pll_locked !== 1'b1; i++) @(posedge aclk);
      rd(IDX_CLOCK_STATUS, {13'h0000, cur != RATIO_BYPASS, 2'h1}, RESP_OKAY);
      chk_clk(cur);
    end
    $display("test ratio codes done");
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    cmp("gate", 1'b0, gate);
    open_gate();
    rd(IDX_PLL_RATIO, {12'h000, cur}, RESP_OKAY);
    rd(IDX_FAST_PRESCALER, 16'h0000, RESP_OKAY);
    chk_clk(cur);
    prsc_osc_model_i.pin_reset(1'b1);
    open_gate();
    rd(IDX_PLL_RATIO, 16'(RATIO_RESET), RESP_OKAY);
    chk_clk(RATIO_RESET);
    $display("test resets done");
    prsc_osc_model_i.pin_reset(1'b0);
    rd(IDX_CLOCK_STATUS, 16'h0003, RESP_OKAY);
    cmp("strap_num", NUM_ONE, cnum);
    cmp("strap_den", DEN_ONE, cden);
    cmp("strap_on", 1'b0, pll_enable);
    $display("test strap done");
    report_and_stop();
  end
endmodule : prsc_top_test

`default_nettype wire
